// ---- art_timer.sv ----
// auto-reload 16-bit / split dual 8-bit timer with comparator capture
// counter, reload pair, control, clock selects and sync status behind a 3-bit register port
// assumes synchronous inputs except the external source, one clock, and a register master that never waits
// suspend comes from the power control; wake is a one-clock pulse back to it
// the external source is a free-running level; the comparator level is edge-detected here
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none
module art_timer (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   // register port
   input wire logic [2:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   // far side: external source and comparator
   input wire logic i_ext_osc,
   input wire logic i_cmp_out,
   // power control
   input wire logic i_suspend,
   // registered outputs
   output logic [7:0] o_rdata,
   output logic o_irq,
   output logic o_wake
);

   typedef struct packed {
      // live counter bytes
      logic [7:0] cnt_lo;
      logic [7:0] cnt_hi;
      // reload bytes, also the capture destination
      logic [7:0] rld_lo;
      logic [7:0] rld_hi;

      // overflow flags, set by hardware, cleared only by software
      logic high_flag;
      logic low_flag;
      // timer control bits
      logic low_irq_en;
      logic capture_en;
      logic split;
      logic run;
      logic ext_sel;

      // clock control bits
      logic low_sel;
      logic high_sel;
      logic timer_irq_en;

      // prescalers: /12 free-running, /8 counts external edges
      logic [3:0] div12;
      logic [2:0] div8;

      // two-flop synchroniser plus its edge history
      logic ext_meta;
      logic ext_sync;
      logic ext_sync_d;
      // raw sampler used only while suspended
      logic ext_raw;
      // comparator level one clock back, for the rising-edge detect
      logic cmp_q;

      // suspend tracking and sync pending counter
      logic susp_q;
      logic woke_by_timer;
      logic [1:0] sync_cnt;

      // registered outputs
      logic [7:0] rdata;
      logic irq;
      logic wake;
   } art_state_t;

   art_state_t s_q;
   art_state_t s_d;

   // per-byte clock choice: 1 picks system clock, else the external select decides
   function automatic logic art_pick_tick(input logic sel, input logic xsel, input logic ext_t,
                                          input logic d12_t);
      art_pick_tick = sel ? 1'b1 : (xsel ? ext_t : d12_t);
   endfunction : art_pick_tick

   // true when a strobe addresses the given register index
   function automatic logic art_hit(input logic strobe, input logic [2:0] addr, input logic [2:0] idx);
      art_hit = strobe && (addr == idx);
   endfunction : art_hit

   // tick and event strobes, valid for the current cycle only
   logic ext_edge;
   logic ext_tick;
   logic d12_tick;
   // mode and per-byte count enables
   logic cap_mode;
   logic lo_tick;
   logic hi_tick;
   // rollover and capture events
   logic lo_roll;
   logic hi_roll;
   logic word_roll;
   logic cap_evt;
   // software write to the control register
   logic wr_ctl;

   // order of precedence inside one cycle, lowest first:
   //   count or reload from a tick
   //   capture into the reload pair
   //   software writes to bytes and control
   //   software write to the flags
   //   hardware flag set over that software clear
   // one process for the whole state keeps that order visible
   // and leaves every field with a single driver
   // ticks are one-cycle enables, never derived clocks,
   // so the whole block stays in the system clock domain
   // next-state logic for the whole block
   always_comb begin
      // everything holds unless a branch below overrides it
      s_d = s_q;
      // first stage feeds only the second; direct path has its own sampler
      s_d.ext_meta = i_ext_osc;
      s_d.ext_sync = s_q.ext_meta;
      s_d.ext_sync_d = s_q.ext_sync;
      s_d.ext_raw = i_ext_osc;
      s_d.cmp_q = i_cmp_out;
      s_d.susp_q = i_suspend;

      // the synchronised edge lags the pin by two clocks; in suspend the
      // system clock may be slowed, so that lag is not acceptable there
      // a switch between the two paths may add or drop one external edge
      // in suspend the raw edge is used, trading metastability margin for no latency
      if (i_suspend) begin
         ext_edge = i_ext_osc & ~s_q.ext_raw;
      end else begin
         ext_edge = s_q.ext_sync & ~s_q.ext_sync_d;
      end

      // dividers: /12 runs from reset regardless of mode, so its phase
      // is unrelated to any register write
      // the /8 stage only moves on external edges
      d12_tick = (s_q.div12 == art_pkg::SYS_DIV_LAST);
      s_d.div12 = d12_tick ? 4'h0 : s_q.div12 + 4'h1;
      ext_tick = ext_edge && (s_q.div8 == art_pkg::EXT_DIV_LAST);
      if (ext_edge) begin
         s_d.div8 = s_q.div8 + 3'h1;
      end

      // capture needs split clear; setting split drops capture at once
      cap_mode = s_q.capture_en & ~s_q.split;

      // in 16-bit mode the high select is ignored; the low select drives the word
      // the high byte then never ticks on its own, the carry comes from the add
      // capture mode forces the external choice back onto system clock /12
      lo_tick = art_pick_tick(s_q.low_sel, s_q.ext_sel & ~cap_mode, ext_tick, d12_tick);
      hi_tick = art_pick_tick(s_q.high_sel, s_q.ext_sel, ext_tick, d12_tick);
      if (s_q.split) begin
         hi_tick = hi_tick & s_q.run;
      end else begin
         lo_tick = lo_tick & s_q.run;
         hi_tick = 1'b0;
      end

      // rollovers are judged on the current value, before this cycle's increment
      // capture mode lets the word wrap freely, so no reload there
      // the low rollover counts in every mode, for the low flag
      lo_roll = lo_tick && (s_q.cnt_lo == art_pkg::BYTE_MAX);
      hi_roll = hi_tick && (s_q.cnt_hi == art_pkg::BYTE_MAX);
      word_roll = lo_tick && ({s_q.cnt_hi, s_q.cnt_lo} == art_pkg::WORD_MAX) && !cap_mode;
      cap_evt = cap_mode && i_cmp_out && !s_q.cmp_q;
      // flag writes are decoded apart so the hardware set can follow them
      wr_ctl = art_hit(i_wr, i_addr, art_pkg::ADDR_TIMER_CTRL);

      // counting: split gives each byte its own reload,
      // 16-bit mode carries from the low byte through the add
      // a stopped run bit freezes the word but not the low byte in split
      if (s_q.split) begin
         if (lo_tick) begin
            s_d.cnt_lo = lo_roll ? s_q.rld_lo : s_q.cnt_lo + 8'h01;
         end
         if (hi_tick) begin
            s_d.cnt_hi = hi_roll ? s_q.rld_hi : s_q.cnt_hi + 8'h01;
         end
      end else if (lo_tick) begin
         if (word_roll) begin
            s_d.cnt_lo = s_q.rld_lo;
            s_d.cnt_hi = s_q.rld_hi;
         end else begin
            {s_d.cnt_hi, s_d.cnt_lo} = {s_q.cnt_hi, s_q.cnt_lo} + 16'h0001;
         end
      end

      // capture overwrites the reload pair; a reload write in the same cycle wins
      if (cap_evt) begin
         s_d.rld_lo = s_q.cnt_lo;
         s_d.rld_hi = s_q.cnt_hi;
      end

      // register writes land next clock and beat counting in the same cycle
      // the unmapped index falls to the default branch and is ignored
      if (i_wr) begin
         case (i_addr)
            art_pkg::ADDR_COUNT_LOW: s_d.cnt_lo = i_wdata;
            art_pkg::ADDR_COUNT_HIGH: s_d.cnt_hi = i_wdata;
            art_pkg::ADDR_RELOAD_LOW: s_d.rld_lo = i_wdata;
            art_pkg::ADDR_RELOAD_HIGH: s_d.rld_hi = i_wdata;
            art_pkg::ADDR_TIMER_CTRL: begin
               s_d.low_irq_en = i_wdata[art_pkg::CTL_LOW_IRQ_EN];
               s_d.capture_en = i_wdata[art_pkg::CTL_CAPTURE_EN];
               s_d.split = i_wdata[art_pkg::CTL_SPLIT];
               s_d.run = i_wdata[art_pkg::CTL_RUN];
               s_d.ext_sel = i_wdata[art_pkg::CTL_EXT_SEL];
            end
            art_pkg::ADDR_CLOCK_CTRL: begin
               s_d.low_sel = i_wdata[art_pkg::CKC_LOW_SEL];
               s_d.high_sel = i_wdata[art_pkg::CKC_HIGH_SEL];
               s_d.timer_irq_en = i_wdata[art_pkg::CKC_TIMER_IRQ_EN];
            end
            default: begin
            end
         endcase
      end

      // flags: only software clears, and a hardware set wins over that clear
      // the written value is taken, so software may also set a flag
      if (wr_ctl) begin
         s_d.high_flag = i_wdata[art_pkg::CTL_HIGH_FLAG];
         s_d.low_flag = i_wdata[art_pkg::CTL_LOW_FLAG];
      end
      if (word_roll || hi_roll || cap_evt) begin
         s_d.high_flag = 1'b1;
      end
      if (lo_roll) begin
         s_d.low_flag = 1'b1;
      end

      // interrupt request level, same equation for both counter modes
      // one cycle behind the flags; clearing the flags drops the request
      // the low flag only asks for service when its own enable is set
      s_d.irq = s_q.timer_irq_en & (s_q.high_flag | (s_q.low_irq_en & s_q.low_flag));

      // wake pulse on word overflow outside capture or split high-byte overflow while suspended; captures never wake, split low rollovers only at cnt_hi FF
      s_d.wake = i_suspend && (word_roll || (s_q.split && hi_roll));
      if (i_suspend && !s_q.susp_q) begin
         s_d.woke_by_timer = 1'b0;
      end else if (s_d.wake) begin
         s_d.woke_by_timer = 1'b1;
      end

      // sync pending after a wake from some other source, counted in external /8 ticks
      // a wake by the timer itself needs no resync, the count never stopped
      // writes are not blocked here; software polls the status bit
      if (!i_suspend && s_q.susp_q && !s_q.woke_by_timer && !s_d.wake) begin
         s_d.sync_cnt = art_pkg::SYNC_HOLD_TICKS;
      end else if (s_q.sync_cnt != 2'h0 && ext_tick) begin
         s_d.sync_cnt = s_q.sync_cnt - 2'h1;
      end

      // read data stands only in the cycle after the strobe
      // unused control bit and unmapped index read zero
      s_d.rdata = art_pkg::BYTE_RESET;
      if (i_rd) begin
         case (i_addr)
            art_pkg::ADDR_COUNT_LOW: s_d.rdata = s_q.cnt_lo;
            art_pkg::ADDR_COUNT_HIGH: s_d.rdata = s_q.cnt_hi;
            art_pkg::ADDR_RELOAD_LOW: s_d.rdata = s_q.rld_lo;
            art_pkg::ADDR_RELOAD_HIGH: s_d.rdata = s_q.rld_hi;
            art_pkg::ADDR_TIMER_CTRL: begin
               s_d.rdata[art_pkg::CTL_HIGH_FLAG] = s_q.high_flag;
               s_d.rdata[art_pkg::CTL_LOW_FLAG] = s_q.low_flag;
               s_d.rdata[art_pkg::CTL_LOW_IRQ_EN] = s_q.low_irq_en;
               s_d.rdata[art_pkg::CTL_CAPTURE_EN] = s_q.capture_en;
               s_d.rdata[art_pkg::CTL_SPLIT] = s_q.split;
               s_d.rdata[art_pkg::CTL_RUN] = s_q.run;
               s_d.rdata[art_pkg::CTL_EXT_SEL] = s_q.ext_sel;
            end
            art_pkg::ADDR_CLOCK_CTRL: begin
               s_d.rdata[art_pkg::CKC_LOW_SEL] = s_q.low_sel;
               s_d.rdata[art_pkg::CKC_HIGH_SEL] = s_q.high_sel;
               s_d.rdata[art_pkg::CKC_TIMER_IRQ_EN] = s_q.timer_irq_en;
            end
            art_pkg::ADDR_STATUS: s_d.rdata[art_pkg::STS_SYNC_PENDING] = (s_q.sync_cnt != 2'h0);
            default: s_d.rdata = art_pkg::BYTE_RESET;
         endcase
      end
   end

   // state register, everything clears on reset
   // synchronous active-low reset; one register holds the whole state
   // so no field can come out of reset on a different edge
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from flops, no logic after the register
   assign o_rdata = s_q.rdata;
   assign o_irq = s_q.irq;
   assign o_wake = s_q.wake;

endmodule : art_timer
`default_nettype wire

// ---- art_pkg.sv ----
// constants shared by the auto-reload timer with comparator capture
// assumes an 8-bit register port and a single system clock domain
package art_pkg;
   // register indices on the 3-bit address port
   localparam logic [2:0] ADDR_COUNT_LOW = 3'h0;
   localparam logic [2:0] ADDR_COUNT_HIGH = 3'h1;
   localparam logic [2:0] ADDR_RELOAD_LOW = 3'h2;
   localparam logic [2:0] ADDR_RELOAD_HIGH = 3'h3;
   localparam logic [2:0] ADDR_TIMER_CTRL = 3'h4;
   localparam logic [2:0] ADDR_CLOCK_CTRL = 3'h5;
   localparam logic [2:0] ADDR_STATUS = 3'h6;
   // timer_control_register bit positions
   localparam int CTL_HIGH_FLAG = 7;
   localparam int CTL_LOW_FLAG = 6;
   localparam int CTL_LOW_IRQ_EN = 5;
   localparam int CTL_CAPTURE_EN = 4;
   localparam int CTL_SPLIT = 3;
   localparam int CTL_RUN = 2;
   localparam int CTL_EXT_SEL = 0;
   // clock_control_register bit positions
   localparam int CKC_LOW_SEL = 0;
   localparam int CKC_HIGH_SEL = 1;
   localparam int CKC_TIMER_IRQ_EN = 2;
   // status register bit positions
   localparam int STS_SYNC_PENDING = 0;
   // reset values and rollover points
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [7:0] BYTE_MAX = 8'hFF;
   localparam logic [15:0] WORD_MAX = 16'hFFFF;
   // clock dividers and sync hold
   localparam int SYS_DIV = 12;
   localparam int EXT_DIV = 8;
   localparam logic [3:0] SYS_DIV_LAST = 4'(SYS_DIV - 1);
   localparam logic [2:0] EXT_DIV_LAST = 3'(EXT_DIV - 1);
   localparam logic [1:0] SYNC_HOLD_TICKS = 2'h3;
endpackage : art_pkg

// ---- art_timer_props.sv ----
// checker on the timer's register port, interrupt and wake outputs
// assumes a bind onto art_timer: one clock, synchronous active-low reset
`timescale 1ns/1ns
`default_nettype none
module art_timer_props (
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire logic [2:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_ext_osc,
   input wire logic i_cmp_out,
   input wire logic i_suspend,
   input wire logic [7:0] o_rdata,
   input wire logic o_irq,
   input wire logic o_wake
);
   // one domain, so clock and reset are given once
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rst_b);
   // read port answers only in the cycle after a strobe
   a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data outside an answer");
   a_reset_quiet: assert property ($rose(i_rst_b) |-> !o_irq && !o_wake && o_rdata == 8'h00)
      else $error("outputs busy after reset");
   a_wake_in_suspend: assert property (o_wake |-> $past(i_suspend))
      else $error("wake outside suspend");
   // write then read of the same place returns the written control and select bits; bit 1 reads 0
   a_ctl_read_back: assert property (
      i_wr && i_addr == 3'h4 ##1 i_rd && i_addr == 3'h4 |=> o_rdata[5:0] == ($past(i_wdata[5:0], 2) & 6'h3D))
      else $error("control bits lost");
   a_sel_read_back: assert property (
      i_wr && i_addr == 3'h5 ##1 i_rd && i_addr == 3'h5 |=> o_rdata[2:0] == $past(i_wdata[2:0], 2))
      else $error("select bits lost");
   // a comparator edge would overwrite the reload byte, so keep it low
   a_reload_read_back: assert property (
      i_wr && i_addr == 3'h2 && !i_cmp_out ##1 i_rd && i_addr == 3'h2 && !i_cmp_out |=> o_rdata == $past(i_wdata, 2))
      else $error("reload byte lost");
   // the write beats a tick in its cycle, so the answer is the written byte; the check allows one step
   a_count_step: assert property (
      i_wr && i_addr == 3'h0 && i_wdata != 8'hFF ##1 i_rd && i_addr == 3'h0 |=> 8'(o_rdata - $past(i_wdata, 2)) <= 8'h01)
      else $error("count byte write lost");
   a_irq_off: assert property (i_wr && i_addr == 3'h5 && !i_wdata[2] |=> ##1 !o_irq)
      else $error("irq with enable off");
endmodule : art_timer_props
`default_nettype wire

// ---- art_far.sv ----
// model of the external oscillator source and the comparator output
// assumes the bench enables the source and raises the comparator by level
`timescale 1ns/1ns
`default_nettype none
module art_far (
   input wire logic i_osc_en,
   input wire logic i_cmp_req,
   output logic o_ext_osc,
   output var logic o_cmp_out
);
   // period unrelated to the system clock; parked low while disabled
   // toggles never land on rising system edges, so sampling never races them
   initial begin
      o_ext_osc = 1'b0;
      forever #70 o_ext_osc = i_osc_en ? !o_ext_osc : 1'b0;
   end
   // comparator edges come far slower than the counter clock
   assign o_cmp_out = i_cmp_req;
endmodule : art_far
`default_nettype wire

// ---- autoreload_timer_capture_bench.sv ----
// self-checking bench: register-port tasks driving art_timer and art_far
// assumes a 50 ns clock and the register map of art_pkg
`timescale 1ns/1ns
`default_nettype none
module autoreload_timer_capture_bench;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic sus = 1'b0;
   logic cmp_req = 1'b0;
   logic osc_en = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00;
   logic ext_osc, cmp_out, irq, wake;
   logic [7:0] rdata;
   int bad_count = 0;
   int n_tests = 0;
   art_timer i_dut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s),
      .i_rd(rd_s), .i_ext_osc(ext_osc), .i_cmp_out(cmp_out), .i_suspend(sus), .o_rdata(rdata),
      .o_irq(irq), .o_wake(wake));
   art_far i_far (.i_osc_en(osc_en), .i_cmp_req(cmp_req), .o_ext_osc(ext_osc), .o_cmp_out(cmp_out));
   // system clock
   initial begin
      forever #25 clk = !clk;
   end
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : tally_and_finish
   // write strobe stays up until the next task moves on, so writes can run back to back
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      wr_s <= 1'b1;
      rd_s <= 1'b0;
      addr <= a;
      wdata <= d;
      @(posedge clk);
   endtask : wr
   task automatic tick(input int n);
      wr_s <= 1'b0;
      rd_s <= 1'b0;
      repeat (n) @(posedge clk);
   endtask : tick
   task automatic rdchk(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
      wr_s <= 1'b0;
      rd_s <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_s <= 1'b0;
      @(negedge clk);
      n_tests++;
      if ((rdata & m) !== (e & m)) begin
         bad_count++;
         $display("ERROR reg %0d expected %h seen %h", a, e & m, rdata & m);
      end
      @(posedge clk);
   endtask : rdchk
   task automatic chk_irq(input logic e);
      @(negedge clk);
      n_tests++;
      if (irq !== e) begin
         bad_count++;
         $display("ERROR irq expected %b seen %b", e, irq);
      end
      @(posedge clk);
   endtask : chk_irq
   // bounded wait for irq (pick 0) or wake (pick 1)
   task automatic wait_out(input logic pick, input int lim);
      tick(0);
      n_tests++;
      for (int i = 0; i < lim; i++) begin
         @(negedge clk);
         if ((pick ? wake : irq) === 1'b1) begin
            @(posedge clk);
            return;
         end
      end
      bad_count++;
      $display("ERROR %s expected 1 seen 0", pick ? "wake" : "irq");
      tally_and_finish();
   endtask : wait_out
   // reset, then the tests in turn
   initial begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      for (int a = 0; a < 8; a++) rdchk(3'(a), 8'h00, 8'hFF);
      wr(3'h7, 8'hAA);
      rdchk(3'h7, 8'h00, 8'hFF);
      $display("test reset_map done");
      wr(3'h3, 8'h12);
      wr(3'h2, 8'h34);
      rdchk(3'h2, 8'h34, 8'hFF);
      wr(3'h5, 8'h05);
      rdchk(3'h5, 8'h05, 8'h07);
      wr(3'h4, 8'h00);
      rdchk(3'h4, 8'h00, 8'hFF);
      wr(3'h1, 8'hFF);
      wr(3'h0, 8'hFE);
      rdchk(3'h0, 8'hFE, 8'hFF);
      wr(3'h4, 8'h04);
      wait_out(1'b0, 20);
      rdchk(3'h4, 8'h84, 8'hBF);
      rdchk(3'h1, 8'h12, 8'hFF);
      wr(3'h5, 8'h01);
      tick(3);
      chk_irq(1'b0);
      wr(3'h4, 8'h24);
      wr(3'h5, 8'h05);
      wait_out(1'b0, 300);
      rdchk(3'h4, 8'h64, 8'hFF);
      $display("test sixteen_bit done");
      wr(3'h4, 8'h08);
      wr(3'h5, 8'h07);
      wr(3'h1, 8'hF0);
      wr(3'h3, 8'hF0);
      wr(3'h2, 8'hA0);
      wr(3'h0, 8'hF0);
      tick(40);
      rdchk(3'h1, 8'hF0, 8'hFF);
      rdchk(3'h4, 8'h48, 8'hFF);
      chk_irq(1'b0);
      wr(3'h4, 8'h68);
      tick(3);
      chk_irq(1'b1);
      wr(3'h4, 8'h0C);
      tick(20);
      rdchk(3'h4, 8'h8C, 8'hBF);
      rdchk(3'h1, 8'hF0, 8'hF0);
      $display("test split done");
      wr(3'h4, 8'h14);
      wr(3'h1, 8'h55);
      wr(3'h0, 8'h00);
      cmp_req <= 1'b1;
      tick(6);
      rdchk(3'h3, 8'h55, 8'hFF);
      rdchk(3'h4, 8'h94, 8'hBF);
      cmp_req <= 1'b0;
      $display("test capture done");
      wr(3'h4, 8'h05);
      wr(3'h5, 8'h04);
      wr(3'h1, 8'hFF);
      wr(3'h0, 8'hFE);
      osc_en <= 1'b1;
      sus <= 1'b1;
      wait_out(1'b1, 500);
      sus <= 1'b0;
      tick(3);
      rdchk(3'h1, 8'h55, 8'hFF);
      rdchk(3'h6, 8'h00, 8'h01);
      wr(3'h1, 8'h00);
      wr(3'h0, 8'h00);
      sus <= 1'b1;
      tick(5);
      sus <= 1'b0;
      tick(3);
      rdchk(3'h6, 8'h01, 8'h01);
      tick(100);
      rdchk(3'h6, 8'h00, 8'h01);
      $display("test suspend done");
      tally_and_finish();
   end
endmodule : autoreload_timer_capture_bench
bind art_timer art_timer_props i_props (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_ext_osc(i_ext_osc), .i_cmp_out(i_cmp_out),
   .i_suspend(i_suspend), .o_rdata(o_rdata), .o_irq(o_irq), .o_wake(o_wake));
`default_nettype wire
